// ### rtl/tpc_probe.sv
`timescale 1ns/1ps
`include "tpc_defs.svh"

// ----------------------------------------------------------------
// dual-clock fifo, gray pointers
// ----------------------------------------------------------------
module tpc_fifo #(
  parameter int WIDTH = `TPC_ENTRY_W,
  parameter int DEPTH = `TPC_FIFO_DEPTH
) (
  input wire logic wclk,
  input wire logic wrst_b,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rclk,
  input wire logic rrst_b,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin, wgray, next_wbin;
  logic [AW:0] rbin, rgray, next_rbin;
  logic [AW:0] rg1, rg2, rg3;
  logic [AW:0] wg1, wg2, wg3;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  always_comb
  begin
    wr_ready = (wgray != {~rg3[AW:AW-1], rg3[AW-2:0]});
    next_wbin = wbin + {{AW{1'b0}}, (wr_valid & wr_ready)};
    rd_valid = (rgray != wg3);
    rd_data = mem[rbin[AW-1:0]];
    next_rbin = rbin + {{AW{1'b0}}, (rd_valid & rd_ready)};
  end

  always_ff @(posedge wclk)
  begin
    if (!wrst_b)
    begin
      wbin <= '0;
      wgray <= '0;
      rg1 <= '0;
      rg2 <= '0;
      rg3 <= '0;
    end
    else
    begin
      if (wr_valid && wr_ready)
        mem[wbin[AW-1:0]] <= wr_data;
      wbin <= next_wbin;
      wgray <= to_gray(next_wbin);
      rg1 <= rgray;
      rg2 <= rg1;
      rg3 <= rg2;
    end
  end

  always_ff @(posedge rclk)
  begin
    if (!rrst_b)
    begin
      rbin <= '0;
      rgray <= '0;
      wg1 <= '0;
      wg2 <= '0;
      wg3 <= '0;
    end
    else
    begin
      rbin <= next_rbin;
      rgray <= to_gray(next_rbin);
      wg1 <= wgray;
      wg2 <= wg1;
      wg3 <= wg2;
    end
  end
endmodule

module tpc_probe
  import tpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  tpc_if.probe link,
  input wire tpc_pkg::tpc_arch_t cfg_arch,
  input wire tpc_pkg::tpc_width_t cfg_width,
  input wire logic cfg_half_rate,
  input wire logic capture_en,
  output logic out_valid,
  input wire logic out_ready,
  output tpc_pkg::tpc_word_t out_word,
  output logic capture_overflow,
  input wire logic jtag_tck,
  input wire logic jtag_tms,
  input wire logic jtag_tdi,
  input wire logic debug_request,
  input wire logic target_reset_req,
  output logic tdo_seen,
  output logic returned_clock_seen,
  output logic debug_ack_seen
);
  // ----------------------------------------------------------------
  // link domain: trace clock
  // ----------------------------------------------------------------
  logic [2:0] lrst_s, en_s, half_s;
  logic en_l, half_l, next_en_l, next_half_l;
  logic [`TPC_PINS-1:0] fall_pins;
  logic fall_ok;
  logic wr_ready, ovf_l;
  logic cap_run, half_q;
  logic rd_valid, rd_ready;
  logic [`TPC_ENTRY_W-1:0] wr_data, rd_data;

  always_comb
  begin
    // a level from the other domain counts once stages two and three agree
    next_en_l = (en_s[1] == en_s[2]) ? en_s[2] : en_l;
    next_half_l = (half_s[1] == half_s[2]) ? half_s[2] : half_l;
    // one entry per rising edge keeps the write port single
    wr_data = {half_l & fall_ok, fall_pins, link.trace_pins};
  end

  always_ff @(posedge link.trace_clock)
  begin
    lrst_s <= {lrst_s[1:0], rst_b};
    if (!lrst_s[2])
    begin
      en_s <= 3'h0;
      half_s <= 3'h0;
      en_l <= 1'b0;
      half_l <= 1'b0;
      ovf_l <= 1'b0;
    end
    else
    begin
      en_s <= {en_s[1:0], cap_run};
      half_s <= {half_s[1:0], half_q};
      en_l <= next_en_l;
      half_l <= next_half_l;
      // a full fifo cannot stall the target, so the sample is lost and flagged
      ovf_l <= ovf_l | (en_l & ~wr_ready);
    end
  end

  // one flop per edge, no rate-dependent logic: any period the pads pass
  always_ff @(negedge link.trace_clock)
  begin
    fall_pins <= link.trace_pins;
    fall_ok <= en_l;
  end

  tpc_fifo #(
    .WIDTH(`TPC_ENTRY_W),
    .DEPTH(`TPC_FIFO_DEPTH)
  ) u_fifo (
    .wclk(link.trace_clock),
    .wrst_b(lrst_s[2]),
    .wr_valid(en_l),
    .wr_ready(wr_ready),
    .wr_data(wr_data),
    .rclk(clk),
    .rrst_b(rst_b),
    .rd_valid(rd_valid),
    .rd_ready(rd_ready),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // system domain: configuration and decode
  // ----------------------------------------------------------------
  logic [`TPC_ENTRY_W-1:0] entry, next_entry;
  tpc_arch_t arch_q, next_arch_q;
  tpc_width_t width_q, next_width_q;
  logic next_half_q, next_cap_run;
  tpc_state_t state, next_state;
  logic next_out_valid;
  tpc_word_t next_out_word;
  logic [2:0] sy1, sy2, sy3, seen, next_seen;
  logic [2:0] ovf_s;
  logic next_ovf;
  logic [2:0] lnk_s;
  logic lnk_on, next_lnk_on;

  function automatic logic [15:0] width_mask(input tpc_width_t w);
    case (w)
      TPC_WIDTH_4: return 16'h000F;
      TPC_WIDTH_8: return 16'h00FF;
      default: return 16'hFFFF;
    endcase
  endfunction

  function automatic tpc_word_t decode(input logic [`TPC_PINS-1:0] p, input tpc_arch_t a,
                                       input tpc_width_t w);
    tpc_word_t d;
    d = '0;
    case (a)
      TPC_ARCH_V1:
      begin
        d.pipeline_status = {1'b0, p[2:0]};
        d.trace_sync_flag = p[3];
        d.trace_packet = p[19:4] & width_mask(w);
      end
      TPC_ARCH_V2:
      begin
        d.pipeline_status = p[3:0];
        d.trace_packet = p[19:4] & width_mask(w);
      end
      default:
      begin
        // pins 2 to 4 are tied levels and carry nothing
        d.trace_control_flag = p[1];
        d.trace_data_bus = {p[19:5], p[0]} & width_mask(w);
      end
    endcase
    return d;
  endfunction

  always_comb
  begin
    next_cap_run = capture_en;
    next_arch_q = arch_q;
    next_width_q = width_q;
    next_half_q = half_q;
    // settings load only while stopped and drained; the link side keeps writing
    // for a few trace edges after stop, so its own enable must be seen low too
    if (!cap_run && !lnk_on && !rd_valid && state == TPC_ST_IDLE)
    begin
      next_arch_q = cfg_arch;
      next_width_q = cfg_width;
      next_half_q = cfg_half_rate;
    end
    next_state = state;
    next_entry = entry;
    next_out_valid = out_valid;
    next_out_word = out_word;
    rd_ready = 1'b0;
    case (state)
      TPC_ST_LO:
      begin
        if (out_ready)
        begin
          next_out_word = decode(entry[`TPC_PINS-1:0], arch_q, width_q);
          next_state = TPC_ST_HI;
        end
      end
      TPC_ST_IDLE, TPC_ST_HI:
      begin
        if (state == TPC_ST_IDLE || out_ready)
        begin
          next_out_valid = 1'b0;
          next_state = TPC_ST_IDLE;
          if (rd_valid)
          begin
            rd_ready = ce;
            next_entry = rd_data;
            next_out_valid = 1'b1;
            if (rd_data[`TPC_ENTRY_PAIR])
            begin
              next_out_word = decode(rd_data[`TPC_ENTRY_FALL_LSB +: `TPC_PINS], arch_q,
                                     width_q);
              next_state = TPC_ST_LO;
            end
            else
            begin
              next_out_word = decode(rd_data[`TPC_PINS-1:0], arch_q, width_q);
              next_state = TPC_ST_HI;
            end
          end
        end
      end
      default: next_state = TPC_ST_IDLE;
    endcase
    // majority of stages two and three with the held value as tie-break
    next_seen = (sy2 & sy3) | (seen & (sy2 | sy3));
    next_ovf = (ovf_s[1] == ovf_s[2]) ? ovf_s[2] : capture_overflow;
    next_lnk_on = (lnk_s[1] == lnk_s[2]) ? lnk_s[2] : lnk_on;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cap_run <= 1'b0;
      arch_q <= TPC_ARCH_V1;
      width_q <= TPC_WIDTH_16;
      half_q <= 1'b0;
      state <= TPC_ST_IDLE;
      entry <= '0;
      out_valid <= 1'b0;
      out_word <= '0;
      sy1 <= 3'h0;
      sy2 <= 3'h0;
      sy3 <= 3'h0;
      seen <= 3'h0;
      ovf_s <= 3'h0;
      lnk_s <= 3'h0;
      lnk_on <= 1'b0;
      capture_overflow <= 1'b0;
      link.tck <= 1'b0;
      link.tms <= 1'b1;
      link.tdi <= 1'b0;
      link.debug_request_line <= 1'b0;
      link.target_reset_o <= 1'b0;
      link.target_reset_oe_b <= 1'b1;
    end
    else if (ce)
    begin
      cap_run <= next_cap_run;
      arch_q <= next_arch_q;
      width_q <= next_width_q;
      half_q <= next_half_q;
      state <= next_state;
      entry <= next_entry;
      out_valid <= next_out_valid;
      out_word <= next_out_word;
      sy1 <= {link.debug_acknowledge, link.returned_test_clock, link.tdo};
      sy2 <= sy1;
      sy3 <= sy2;
      seen <= next_seen;
      ovf_s <= {ovf_s[1:0], ovf_l};
      lnk_s <= {lnk_s[1:0], en_l};
      lnk_on <= next_lnk_on;
      capture_overflow <= next_ovf;
      link.tck <= jtag_tck;
      link.tms <= jtag_tms;
      link.tdi <= jtag_tdi;
      link.debug_request_line <= debug_request;
      link.target_reset_o <= 1'b0;
      link.target_reset_oe_b <= ~target_reset_req;
    end
  end

  assign tdo_seen = seen[0];
  assign returned_clock_seen = seen[1];
  assign debug_ack_seen = seen[2];
endmodule

// ### rtl/tpc_target.sv
`timescale 1ns/1ps
`include "tpc_defs.svh"

module tpc_target
  import tpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  tpc_if.target link,
  input wire tpc_pkg::tpc_arch_t arch,
  input wire logic half_rate,
  input wire logic src_valid,
  output logic src_ready,
  input wire tpc_pkg::tpc_word_t src_word,
  input wire logic in_debug,
  input wire logic tdo_value,
  output logic tck_seen,
  output logic tms_seen,
  output logic tdi_seen,
  output logic debug_request_seen,
  output logic target_reset_b_seen
);
  // ----------------------------------------------------------------
  // trace clock divider and pin drive
  // ----------------------------------------------------------------
  localparam logic [7:0] LAST = 8'(`TPC_TRACE_PERIOD_CYC - 1);
  localparam logic [7:0] HALF = 8'(`TPC_TRACE_HALF_CYC);
  localparam logic [7:0] QTR = 8'(`TPC_TRACE_HALF_CYC / 2);

  logic [7:0] cnt, next_cnt;
  logic next_tclk, next_src_ready, take;
  logic [`TPC_PINS-1:0] next_pins;
  logic [4:0] s1, s2, s3, seen, next_seen;

  // cycle after which the pins change: midway in each half in half-rate
  // mode, at the falling edge otherwise, so every sampling edge sees stable data
  function automatic logic is_update(input logic [7:0] c, input logic h);
    if (h)
      return (c == QTR - 8'h01) || (c == HALF + QTR - 8'h01);
    return c == HALF - 8'h01;
  endfunction

  function automatic logic [`TPC_PINS-1:0] encode(input tpc_word_t w, input tpc_arch_t a);
    case (a)
      TPC_ARCH_V1: return {w.trace_packet, w.trace_sync_flag, w.pipeline_status[2:0]};
      TPC_ARCH_V2: return {w.trace_packet, w.pipeline_status};
      default: return {w.trace_data_bus[15:1], 3'h1, w.trace_control_flag,
                       w.trace_data_bus[0]};
    endcase
  endfunction

  always_comb
  begin
    next_cnt = (cnt == LAST) ? 8'h00 : cnt + 8'h01;
    next_tclk = next_cnt < HALF;
    next_src_ready = is_update(next_cnt, half_rate);
    take = src_ready & src_valid;
    next_pins = take ? encode(src_word, arch) : link.trace_pins;
    next_seen = (s2 & s3) | (seen & (s2 | s3));
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt <= 8'h00;
      link.trace_clock <= 1'b1;
      link.trace_pins <= `TPC_PINS_RST;
      src_ready <= 1'b0;
      link.debug_acknowledge <= 1'b0;
      link.tdo <= 1'b0;
      link.returned_test_clock <= 1'b0;
      // idle line levels, so the reset line is not seen to dip after reset
      s1 <= 5'h10;
      s2 <= 5'h10;
      s3 <= 5'h10;
      seen <= 5'h10;
    end
    else if (ce)
    begin
      cnt <= next_cnt;
      link.trace_clock <= next_tclk;
      link.trace_pins <= next_pins;
      src_ready <= next_src_ready;
      link.debug_acknowledge <= in_debug;
      link.tdo <= tdo_value;
      link.returned_test_clock <= s3[0];
      s1 <= {link.target_reset_b, link.debug_request_line, link.tdi, link.tms, link.tck};
      s2 <= s1;
      s3 <= s2;
      seen <= next_seen;
    end
  end

  assign tck_seen = seen[0];
  assign tms_seen = seen[1];
  assign tdi_seen = seen[2];
  assign debug_request_seen = seen[3];
  assign target_reset_b_seen = seen[4];
endmodule

// ### shared/tpc_defs.svh
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

// ----------------------------------------------------------------
// port geometry
// ----------------------------------------------------------------
`define TPC_PINS 20
`define TPC_FIFO_DEPTH 16
// fifo entry: [40] pair flag, [39:20] falling sample, [19:0] rising sample
`define TPC_ENTRY_W 41
`define TPC_ENTRY_PAIR 40
`define TPC_ENTRY_FALL_LSB 20
`define TPC_PINS_RST 20'h00004

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TPC_CLK_PERIOD_NS 25
`define TPC_TRACE_PERIOD_MIN_NS 5
`define TPC_TRACE_PERIOD_MAX_NS 1000
`define TPC_HALF_RATE_FREQ_MAX_MHZ 100
`define TPC_TRACE_PERIOD_NS 100
`define TPC_TRACE_PERIOD_CYC (`TPC_TRACE_PERIOD_NS / `TPC_CLK_PERIOD_NS)
`define TPC_TRACE_HALF_CYC (`TPC_TRACE_PERIOD_CYC / 2)

`endif

// ### shared/tpc_if.sv
`timescale 1ns/1ps

`include "tpc_defs.svh"

interface tpc_if;
  logic trace_clock;
  logic [`TPC_PINS-1:0] trace_pins;
  logic debug_request_line;
  logic debug_acknowledge;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic returned_test_clock;
  logic target_reset_o;
  logic target_reset_oe_b;
  logic target_reset_b;

  // open-collector line with a pull-up: only a low can be driven
  assign target_reset_b = target_reset_oe_b ? 1'b1 : target_reset_o;

  modport probe
  (
    input trace_clock,
    input trace_pins,
    input debug_acknowledge,
    input tdo,
    input returned_test_clock,
    output debug_request_line,
    output tck,
    output tms,
    output tdi,
    output target_reset_o,
    output target_reset_oe_b
  );

  modport target
  (
    output trace_clock,
    output trace_pins,
    output debug_acknowledge,
    output tdo,
    output returned_test_clock,
    input debug_request_line,
    input tck,
    input tms,
    input tdi,
    input target_reset_b
  );
endinterface

// ### shared/tpc_pkg.sv
`include "tpc_defs.svh"

package tpc_pkg;

  typedef enum logic [1:0]
  {
    TPC_ARCH_V1 = 2'h1,
    TPC_ARCH_V2 = 2'h2,
    TPC_ARCH_V3 = 2'h3
  } tpc_arch_t;

  typedef enum logic [1:0]
  {
    TPC_WIDTH_4 = 2'h0,
    TPC_WIDTH_8 = 2'h1,
    TPC_WIDTH_16 = 2'h2
  } tpc_width_t;

  typedef enum logic [1:0]
  {
    TPC_ST_IDLE = 2'h0,
    TPC_ST_LO = 2'h1,
    TPC_ST_HI = 2'h3
  } tpc_state_t;

  typedef struct packed
  {
    logic [3:0] pipeline_status;
    logic trace_sync_flag;
    logic trace_control_flag;
    logic [15:0] trace_packet;
    logic [15:0] trace_data_bus;
  } tpc_word_t;

endpackage

// ### verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import tpc_pkg::*;
  logic clk, rst_b, half, cfg_half, capture_en, out_valid, out_ready, capture_overflow;
  logic src_valid, src_ready, jtag_tck, jtag_tms, jtag_tdi, debug_request, target_reset_req;
  logic in_debug, tdo_value, tdo_seen, returned_clock_seen, debug_ack_seen, tck_seen;
  logic tms_seen, tdi_seen, debug_request_seen, target_reset_b_seen, stall, syncing;
  tpc_arch_t cfg_arch, arch;
  tpc_width_t cfg_width, width;
  tpc_word_t out_word, src_word, idle_word;
  tpc_word_t exp_q[$];
  logic [19:0] last_pins;
  integer seed = 92424;
  integer failures = 0;
  integer check_count = 0;

  tpc_if link_if();

  tpc_probe i_tpc_probe (.clk(clk), .rst_b(rst_b), .ce(1'h1), .link(link_if),
    .cfg_arch(cfg_arch), .cfg_width(cfg_width), .cfg_half_rate(cfg_half),
    .capture_en(capture_en), .out_valid(out_valid), .out_ready(out_ready),
    .out_word(out_word), .capture_overflow(capture_overflow), .jtag_tck(jtag_tck),
    .jtag_tms(jtag_tms), .jtag_tdi(jtag_tdi), .debug_request(debug_request),
    .target_reset_req(target_reset_req), .tdo_seen(tdo_seen),
    .returned_clock_seen(returned_clock_seen), .debug_ack_seen(debug_ack_seen));

  tpc_target i_tpc_target (.clk(clk), .rst_b(rst_b), .ce(1'h1), .link(link_if),
    .arch(arch), .half_rate(half), .src_valid(src_valid), .src_ready(src_ready),
    .src_word(src_word), .in_debug(in_debug), .tdo_value(tdo_value), .tck_seen(tck_seen),
    .tms_seen(tms_seen), .tdi_seen(tdi_seen), .debug_request_seen(debug_request_seen),
    .target_reset_b_seen(target_reset_b_seen));

  tpc_link_props i_tpc_link_props (.clk(clk), .rst_b(rst_b), .arch(arch), .half_rate(half),
    .trace_clock(link_if.trace_clock), .trace_pins(link_if.trace_pins), .tck(link_if.tck),
    .returned_test_clock(link_if.returned_test_clock),
    .target_reset_o(link_if.target_reset_o));

  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  function automatic logic [19:0] enc(tpc_arch_t a, tpc_word_t s);
    if (a == TPC_ARCH_V3)
      return {s.trace_data_bus[15:1], 3'h1, s.trace_control_flag, s.trace_data_bus[0]};
    if (a == TPC_ARCH_V2)
      return {s.trace_packet, s.pipeline_status};
    return {s.trace_packet, s.trace_sync_flag, s.pipeline_status[2:0]};
  endfunction

  function automatic tpc_word_t dec(tpc_arch_t a, tpc_width_t w, logic [19:0] p);
    tpc_word_t d;
    logic [15:0] m;
    d = '0;
    m = (w == TPC_WIDTH_4) ? 16'h000F : (w == TPC_WIDTH_8) ? 16'h00FF : 16'hFFFF;
    if (a == TPC_ARCH_V3)
    begin
      d.trace_control_flag = p[1];
      d.trace_data_bus = {p[19:5], p[0]} & m;
    end
    else
    begin
      d.pipeline_status = (a == TPC_ARCH_V2) ? p[3:0] : {1'h0, p[2:0]};
      d.trace_sync_flag = (a == TPC_ARCH_V1) & p[3];
      d.trace_packet = p[19:4] & m;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  task check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      failures++;
    end
  endtask

  task stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task guard(input logic ok);
    if (!ok)
    begin
      failures++;
      stop_test;
    end
  endtask

  task tick;
    @(posedge clk);
    #2;
  endtask

  task new_word;
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    src_word = r[37:0];
  endtask

  // one take per ready slot; the wire is checked right after each take
  task send(input int n, input logic rec);
    int k, b;
    logic took;
    k = 0;
    src_valid = 1;
    // a slot may already be open as valid rises
    took = src_ready;
    for (b = 0; b < 40 * n && k < n; b++)
    begin
      tick;
      if (took)
      begin
        check(link_if.trace_pins, enc(arch, src_word));
        last_pins = enc(arch, src_word);
        if (rec)
          exp_q.push_back(dec(arch, width, last_pins));
        k++;
        new_word();
      end
      if (k == n)
        src_valid = 0;
      took = src_ready & src_valid;
    end
    guard(k == n);
  endtask

  task drain;
    int b, q;
    q = 0;
    for (b = 0; b < 3000 && q < 40; b++)
    begin
      tick;
      q = (out_valid === 1'h0) ? q + 1 : 0;
    end
    guard(q == 40);
  endtask

  // ----------------------------------------------------------------
  // output side: random stalls; leading repeats of the old pins skipped
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    #2;
    out_ready = !stall && ($random(seed) % 4 != 0);
    if (out_valid === 1'h1 && out_ready)
    begin
      if (syncing && out_word !== idle_word)
        syncing = 0;
      if (!syncing && exp_q.size() > 0)
        check(out_word, exp_q.pop_front());
    end
  end

  // config is scrambled once capture runs; decoding must not follow it
  task run(input tpc_arch_t a, input tpc_width_t w, input logic h);
    arch = a;
    width = w;
    half = h;
    cfg_arch = a;
    cfg_width = w;
    cfg_half = h;
    new_word();
    src_word.trace_packet[0] = ~last_pins[4];
    src_word.trace_data_bus[0] = ~last_pins[0];
    idle_word = dec(a, w, last_pins);
    syncing = 1;
    repeat (4) tick;
    capture_en = 1;
    tick;
    cfg_arch = (a == TPC_ARCH_V3) ? TPC_ARCH_V1 : TPC_ARCH_V3;
    cfg_width = (w == TPC_WIDTH_16) ? TPC_WIDTH_4 : TPC_WIDTH_16;
    cfg_half = !h;
    repeat (30) tick;
    send(12, 1);
    repeat (20) tick;
    capture_en = 0;
    drain;
    check(exp_q.size(), 0);
    exp_q.delete();
    $display("test capture arch %0d width %0d half %0d done", a, w, h);
  endtask

  initial
  begin
    logic [63:0] r;
    int a, w, h, i;
    rst_b = 0;
    {capture_en, src_valid, stall, syncing, out_ready, half, cfg_half} = '0;
    {jtag_tck, jtag_tms, jtag_tdi, debug_request, target_reset_req, in_debug, tdo_value} = '0;
    arch = TPC_ARCH_V1;
    cfg_arch = TPC_ARCH_V1;
    width = TPC_WIDTH_16;
    cfg_width = TPC_WIDTH_16;
    src_word = '0;
    last_pins = 20'h00004;
    repeat (12) @(posedge clk);
    #2 rst_b = 1;
    for (a = 1; a < 4; a++)
      for (w = 0; w < 3; w++)
        for (h = 0; h < 2; h++)
          run(tpc_arch_t'(a), tpc_width_t'(w), h[0]);
    for (i = 0; i < 8; i++)
    begin
      r = $random(seed);
      {jtag_tck, jtag_tms, jtag_tdi, debug_request, target_reset_req, in_debug, tdo_value} = r[6:0];
      repeat (10) tick;
      check({link_if.tck, link_if.tms, link_if.tdi, tck_seen, tms_seen, tdi_seen},
        {2{jtag_tck, jtag_tms, jtag_tdi}});
      check({debug_request_seen, link_if.target_reset_oe_b, link_if.target_reset_b,
        target_reset_b_seen}, {debug_request, {3{~target_reset_req}}});
      check({debug_ack_seen, tdo_seen, returned_clock_seen},
        {in_debug, tdo_value, jtag_tck});
    end
    $display("test run control done");
    check(capture_overflow, 1'h0);
    stall = 1;
    capture_en = 1;
    send(40, 0);
    // sixteen entries plus the one held at the output must be exceeded
    repeat (40) tick;
    check({capture_overflow, out_valid}, 2'h3);
    stall = 0;
    capture_en = 0;
    drain;
    $display("test overflow done");
    stop_test;
  end
endmodule

// ### verif/tpc_link_props.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// link checks between the two ends
// ----------------------------------------------------------------
module tpc_link_props
  import tpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire tpc_pkg::tpc_arch_t arch,
  input wire logic half_rate,
  input wire logic trace_clock,
  input wire logic [19:0] trace_pins,
  input wire logic tck,
  input wire logic returned_test_clock,
  input wire logic target_reset_o
);
  import tpc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_trace_period:
    assert property ($rose(trace_clock) |-> trace_clock[*2] ##1 !trace_clock[*2] ##1 trace_clock)
    else $error("trace clock period wrong");
  a_normal_fall:
    assert property (!half_rate && $changed(trace_pins) |-> $fell(trace_clock))
    else $error("pins changed away from falling edge");
  a_half_mid:
    assert property (half_rate && $changed(trace_pins) |-> $stable(trace_clock))
    else $error("pins changed on a sampling edge");
  a_v3_tie_pins:
    assert property (arch == TPC_ARCH_V3 && $changed(trace_pins) |-> trace_pins[4:2] == 3'h1)
    else $error("tied pins wrong");
  a_reset_oc_low:
    assert property (target_reset_o == 1'h0)
    else $error("reset line driven high");
  a_returned_test_clock_rise:
    assert property ($rose(tck) |-> ##[2:6] returned_test_clock)
    else $error("returned clock did not rise");
  a_returned_test_clock_fall:
    assert property ($fell(tck) |-> ##[2:6] !returned_test_clock)
    else $error("returned clock did not fall");
  a_returned_test_clock_steady:
    assert property ($stable(tck)[*7] |-> returned_test_clock == tck)
    else $error("returned clock differs from test clock");
endmodule
